// >>> pmc_pkg.sv
// Package: constants, types and parameter IDs of the parameter store.
// Assumes a single system clock and a host that writes by parameter ID.
`default_nettype none
package pmc_pkg;
    localparam int          PRM_W        = 32;
    localparam int          PRM_N        = 64;
    localparam logic [15:0] PRM_BASE     = 16'h0100;
    localparam logic [5:0]  PRM_LAST     = 6'h3F;
    localparam logic [5:0]  PRM_COMM_LO  = 6'h3C;
    localparam logic [31:0] PRM_INIT_VAL = 32'h0000_0000;
    // Maintenance command IDs
    localparam logic [15:0] ID_ALM_RST   = 16'h00C0;
    localparam logic [15:0] ID_ALMH_CLR  = 16'h00C2;
    localparam logic [15:0] ID_POS_PRE   = 16'h00C5;
    localparam logic [15:0] ID_CONFIG    = 16'h00C6;
    localparam logic [15:0] ID_INIT_KEEP = 16'h00C7;
    localparam logic [15:0] ID_NV_RD     = 16'h00C8;
    localparam logic [15:0] ID_NV_WR     = 16'h00C9;
    localparam logic [15:0] ID_INIT_ALL  = 16'h00CA;
    localparam logic [15:0] ID_BK_RST    = 16'h00CB;
    localparam logic [15:0] ID_BK_SAVE   = 16'h00CC;
    localparam logic [15:0] ID_LAT_CLR   = 16'h00CD;
    localparam logic [15:0] ID_SEQ_CLR   = 16'h00CE;
    localparam logic [15:0] ID_TRIP_CLR  = 16'h00CF;
    localparam logic [15:0] ID_ZR_PRE    = 16'h00D1;
    localparam logic [15:0] ID_ZR_CLR    = 16'h00D2;
    localparam logic [15:0] ID_INFO_CLR  = 16'h00D3;
    localparam logic [15:0] ID_INFH_CLR  = 16'h00D4;
    localparam logic [15:0] ID_ALMH_SEL  = 16'h00D5;
    localparam logic [31:0] ALMH_SEL_RST = 32'h0000_0000;
    localparam logic [31:0] ALMH_SEL_MAX = 32'h0000_000A;
    localparam logic [7:0]  ALM_NONE     = 8'h00;
    localparam logic [7:0]  ALM_NV_ERR   = 8'h41;
    // Guard time after a store write, and its cycle count at 10 MHz
    localparam int          NV_GUARD_S   = 5;
    localparam int          CLK_HZ       = 10_000_000;
    localparam int          NV_GUARD_CYC = NV_GUARD_S * CLK_HZ;
    // Update classes
    localparam logic [1:0]  CLS_A = 2'h0;
    localparam logic [1:0]  CLS_B = 2'h1;
    localparam logic [1:0]  CLS_C = 2'h2;
    localparam logic [1:0]  CLS_D = 2'h3;
    typedef enum {ST_BOOT, ST_IDLE, ST_NVWR, ST_NVRD, ST_INIT} pmc_state_t;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] id;
        logic [31:0] data;
    } pmc_req_t;
    // One-cycle action pulses toward the rest of the driver
    typedef struct packed {
        logic alarm_reset;
        logic alarm_hist_clear;
        logic pos_preset;
        logic backup_restore;
        logic backup_save;
        logic latch_clear;
        logic seq_hist_clear;
        logic trip_clear;
        logic zero_reference_preset;
        logic zero_reference_preset_clear;
        logic info_clear;
        logic info_hist_clear;
    } pmc_act_t;
endpackage
`default_nettype wire

// >>> pmc_top.sv
// Parameter store with working RAM, nonvolatile_store copy, applied set
// and maintenance command decode. Host accesses arrive as ID requests,
// synchronous to core_clk_i; motion and power-fail levels are synchronous.
`timescale 1ns/1ps
`default_nettype none
module pmc_top #(
    parameter int NV_GUARD_CYCLES = pmc_pkg::NV_GUARD_CYC
) (
    input  wire logic             core_clk_i,
    input  wire logic             arst_n_i,
    input  wire pmc_pkg::pmc_req_t req_i,
    output logic                  req_ready_o,
    output logic                  rd_valid_o,
    output logic [31:0]           rd_data_o,
    input  wire logic             motion_busy_i,
    input  wire logic             pwr_fail_i,
    output logic [7:0]            alarm_code_o,
    output logic [3:0]            almh_sel_o,
    output pmc_pkg::pmc_act_t     act_o,
    output logic                  busy_o,
    output logic [5:0]            app_idx_i_echo_o,
    input  wire logic [5:0]       app_idx_i,
    output logic [31:0]           app_data_o
);
    // Parameter index and class; class taken from low index bits
    function automatic logic [1:0] prm_class(input logic [5:0] idx);
        return idx[1:0];
    endfunction

    function automatic logic is_prm(input logic [15:0] id);
        return id[15:6] == pmc_pkg::PRM_BASE[15:6];
    endfunction

    logic [31:0] ram     [pmc_pkg::PRM_N];
    logic [31:0] applied [pmc_pkg::PRM_N];
    logic [31:0] nv      [pmc_pkg::PRM_N];

    pmc_pkg::pmc_state_t state_q, state_d;
    logic [5:0]          idx_q;
    logic                init_all_q;
    logic [63:0]         pend_b_q, pend_c_q;
    logic [31:0]         guard_q;
    logic [7:0]          alarm_q;
    logic [31:0]         sel_q;
    logic [31:0]         rd_q;
    logic                rd_v_q;
    pmc_pkg::pmc_act_t   act_q;
    logic [31:0]         app_q;

    // Request decode; an accepted write is a parameter write or at most one command
    wire        idle    = (state_q == pmc_pkg::ST_IDLE);
    wire        wr_acc  = req_i.wr && idle;
    wire        rd_acc  = req_i.rd && idle;
    wire [5:0]  ridx    = req_i.id[5:0];
    wire        prm_wr  = wr_acc && is_prm(req_i.id);
    wire [1:0]  wr_cls  = prm_class(ridx);
    wire        c_cfg   = wr_acc && (req_i.id == pmc_pkg::ID_CONFIG);
    wire        c_nvwr  = wr_acc && (req_i.id == pmc_pkg::ID_NV_WR);
    wire        c_nvrd  = wr_acc && (req_i.id == pmc_pkg::ID_NV_RD);
    wire        c_ikeep = wr_acc && (req_i.id == pmc_pkg::ID_INIT_KEEP);
    wire        c_iall  = wr_acc && (req_i.id == pmc_pkg::ID_INIT_ALL);
    wire        c_arst  = wr_acc && (req_i.id == pmc_pkg::ID_ALM_RST);
    wire        c_sel   = wr_acc && (req_i.id == pmc_pkg::ID_ALMH_SEL);
    wire        sel_ok  = (req_i.data != 32'h0000_0000) &&
                          (req_i.data <= pmc_pkg::ALMH_SEL_MAX);
    wire        last    = (idx_q == pmc_pkg::PRM_LAST);
    wire        in_guard = (guard_q != 32'h0000_0000);

    // Host sees ready only in idle, so storage commands wait out a batch
    assign req_ready_o = idle;
    assign busy_o      = !idle;

    // Sequencer for boot copy and batch operations
    always_comb begin
        state_d = state_q;
        case (state_q)
            pmc_pkg::ST_BOOT: if (last) state_d = pmc_pkg::ST_IDLE;
            pmc_pkg::ST_IDLE: begin
                if (c_nvwr) state_d = pmc_pkg::ST_NVWR;
                else if (c_nvrd) state_d = pmc_pkg::ST_NVRD;
                else if (c_ikeep || c_iall) state_d = pmc_pkg::ST_INIT;
            end
            default: if (last) state_d = pmc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q    <= pmc_pkg::ST_BOOT;
            idx_q      <= 6'h00;
            init_all_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            idx_q      <= idle ? 6'h00 : idx_q + 6'h01;
            if (c_ikeep || c_iall) init_all_q <= c_iall;
        end
    end

    // Store array has no reset: it models cells that survive power-off
    always_ff @(posedge core_clk_i) begin
        if (state_q == pmc_pkg::ST_NVWR) nv[idx_q] <= ram[idx_q];
    end

    // Working RAM: boot copy, host writes, batch read and init
    always_ff @(posedge core_clk_i) begin
        case (state_q)
            pmc_pkg::ST_BOOT: ram[idx_q] <= nv[idx_q];
            pmc_pkg::ST_NVRD: ram[idx_q] <= nv[idx_q];
            pmc_pkg::ST_INIT: begin
                if (init_all_q || idx_q < pmc_pkg::PRM_COMM_LO)
                    ram[idx_q] <= pmc_pkg::PRM_INIT_VAL;
            end
            default: if (prm_wr) ram[ridx] <= req_i.data;
        endcase
    end

    // Applied set: what the driver really uses, per update class
    always_ff @(posedge core_clk_i) begin
        if (state_q == pmc_pkg::ST_BOOT) begin
            applied[idx_q] <= nv[idx_q];
        end else begin
            for (int i = 0; i < pmc_pkg::PRM_N; i++) begin
                if ((pend_b_q[i] && !motion_busy_i) || (pend_c_q[i] && c_cfg))
                    applied[i] <= ram[i];
            end
            if (prm_wr && wr_cls == pmc_pkg::CLS_A)
                applied[ridx] <= req_i.data;
        end
    end

    // Pending flags; a new write in the apply cycle stays pending
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pend_b_q <= 64'h0;
            pend_c_q <= 64'h0;
        end else begin
            if (!motion_busy_i) pend_b_q <= 64'h0;
            if (c_cfg) pend_c_q <= 64'h0;
            if (prm_wr && wr_cls == pmc_pkg::CLS_B) pend_b_q[ridx] <= 1'b1;
            if (prm_wr && wr_cls == pmc_pkg::CLS_C) pend_c_q[ridx] <= 1'b1;
        end
    end

    // Guard window after a store write; power loss inside it raises 41h
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            guard_q <= 32'h0000_0000;
            alarm_q <= pmc_pkg::ALM_NONE;
        end else begin
            if (state_q == pmc_pkg::ST_NVWR && last)
                guard_q <= 32'(NV_GUARD_CYCLES);
            else if (in_guard)
                guard_q <= guard_q - 32'h0000_0001;
            if (c_arst) alarm_q <= pmc_pkg::ALM_NONE;
            if (pwr_fail_i && (state_q == pmc_pkg::ST_NVWR || in_guard))
                alarm_q <= pmc_pkg::ALM_NV_ERR;
        end
    end

    // Selector, reads and one-cycle action pulses
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sel_q  <= pmc_pkg::ALMH_SEL_RST;
            rd_q   <= 32'h0000_0000;
            rd_v_q <= 1'b0;
            act_q  <= '0;
        end else begin
            if (c_sel && sel_ok) sel_q <= req_i.data;
            rd_v_q <= rd_acc;
            if (rd_acc)
                rd_q <= is_prm(req_i.id) ? ram[ridx] :
                        (req_i.id == pmc_pkg::ID_ALMH_SEL) ? sel_q : 32'h0000_0000;
            act_q.alarm_reset      <= c_arst;
            act_q.alarm_hist_clear <= wr_acc && req_i.id == pmc_pkg::ID_ALMH_CLR;
            act_q.pos_preset       <= wr_acc && req_i.id == pmc_pkg::ID_POS_PRE;
            act_q.backup_restore   <= wr_acc && req_i.id == pmc_pkg::ID_BK_RST;
            act_q.backup_save      <= wr_acc && req_i.id == pmc_pkg::ID_BK_SAVE;
            act_q.latch_clear      <= wr_acc && req_i.id == pmc_pkg::ID_LAT_CLR;
            act_q.seq_hist_clear   <= wr_acc && req_i.id == pmc_pkg::ID_SEQ_CLR;
            act_q.trip_clear       <= wr_acc && req_i.id == pmc_pkg::ID_TRIP_CLR;
            act_q.zero_reference_preset <= wr_acc && req_i.id == pmc_pkg::ID_ZR_PRE;
            act_q.zero_reference_preset_clear <=
                wr_acc && req_i.id == pmc_pkg::ID_ZR_CLR;
            act_q.info_clear       <= wr_acc && req_i.id == pmc_pkg::ID_INFO_CLR;
            act_q.info_hist_clear  <= wr_acc && req_i.id == pmc_pkg::ID_INFH_CLR;
        end
    end

    // Applied value readout for the motion core, registered
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) app_q <= 32'h0000_0000;
        else           app_q <= applied[app_idx_i];
    end

    assign rd_valid_o       = rd_v_q;
    assign rd_data_o        = rd_q;
    assign alarm_code_o     = alarm_q;
    assign almh_sel_o       = sel_q[3:0];
    assign act_o            = act_q;
    assign app_data_o       = app_q;
    assign app_idx_i_echo_o = app_idx_i;

    // Checks: sequencer, batch copies and the store
    AST_BATCH_HOLD: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (state_q == pmc_pkg::ST_NVWR) |-> !req_ready_o)
        else $error("ready during batch write");
    AST_NVWR_COPY: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (state_q == pmc_pkg::ST_NVWR) |=> nv[$past(idx_q)] == $past(ram[idx_q]))
        else $error("store word not copied from RAM");
    AST_BATCH_LEN: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        c_nvrd |=> (state_q == pmc_pkg::ST_NVRD) [*8])
        else $error("batch read cut short");
    AST_BOOT_DONE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        $rose(arst_n_i) |-> ##[0:70] req_ready_o)
        else $error("boot copy too long");
    AST_INIT_KEEP: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (state_q == pmc_pkg::ST_INIT && !init_all_q && idx_q >= pmc_pkg::PRM_COMM_LO)
        |=> ram[$past(idx_q)] == $past(ram[idx_q]))
        else $error("communication setting lost on init");
    AST_INIT_ALL: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (state_q == pmc_pkg::ST_INIT && init_all_q)
        |=> ram[$past(idx_q)] == pmc_pkg::PRM_INIT_VAL)
        else $error("parameter not restored on init");
    AST_RD_DATA: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (rd_acc && is_prm(req_i.id)) |=> rd_data_o == $past(ram[ridx]))
        else $error("read word differs from RAM");

    // Checks: alarm, selector and action pulses
    AST_NV_ALARM: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (pwr_fail_i && state_q == pmc_pkg::ST_NVWR) |=> alarm_code_o == 8'h41)
        else $error("no store alarm on power loss");
    AST_GUARD_LOAD: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (state_q == pmc_pkg::ST_NVWR && last) |=> guard_q == 32'(NV_GUARD_CYCLES))
        else $error("guard not loaded");
    AST_GUARD_ALARM: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (pwr_fail_i && in_guard) |=> alarm_code_o == pmc_pkg::ALM_NV_ERR)
        else $error("no store alarm inside guard time");
    AST_ALM_CLEAR: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (c_arst && !pwr_fail_i) |=> alarm_code_o == 8'h00)
        else $error("alarm reset ignored");
    AST_SEL_RANGE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        sel_q <= pmc_pkg::ALMH_SEL_MAX)
        else $error("selector out of range");
    AST_SEL_IGNORE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (c_sel && !sel_ok) |=> $stable(sel_q))
        else $error("bad selector value taken");
    // The pulse must both appear and end, so a stuck or missing pulse fails
    AST_ACT_ONCE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        c_arst |=> (act_o.alarm_reset and (!c_arst |=> !act_o.alarm_reset)))
        else $error("action pulse not exactly one cycle");

    // Checks: update classes
    AST_CLS_A: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (prm_wr && wr_cls == pmc_pkg::CLS_A && state_q == pmc_pkg::ST_IDLE
         && app_idx_i == ridx ##1 app_idx_i == $past(ridx))
        |=> app_data_o == $past(req_i.data, 2))
        else $error("class A not applied");
    AST_CLS_B: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (prm_wr && wr_cls == pmc_pkg::CLS_B && motion_busy_i) |=> pend_b_q[$past(ridx)])
        else $error("class B not held");
    AST_PEND_B: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (!motion_busy_i && !prm_wr) |=> pend_b_q == 64'h0)
        else $error("class B still pending after stop");
    AST_CLS_C: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (prm_wr && wr_cls == pmc_pkg::CLS_C) |=> pend_c_q[$past(ridx)])
        else $error("class C not held");
    AST_PEND_C: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        c_cfg |=> pend_c_q == 64'h0)
        else $error("class C still pending after configuration");

    // Main scenarios worth seeing at least once
    COV_NVWR: cover property (@(posedge core_clk_i) disable iff (!arst_n_i) c_nvwr);
    COV_CLS_B: cover property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (|pend_b_q) && !motion_busy_i);
    COV_ALARM: cover property (@(posedge core_clk_i) disable iff (!arst_n_i)
        alarm_code_o == 8'h41);
    COV_INIT: cover property (@(posedge core_clk_i) disable iff (!arst_n_i) c_ikeep);
    COV_SEL: cover property (@(posedge core_clk_i) disable iff (!arst_n_i) c_sel && sel_ok);
endmodule // pmc_top
`default_nettype wire

// >>> pmc_host_model.sv
// Host controller model: issues parameter ID reads and writes.
// Assumes requests are taken at a rising edge while ready is high.
`timescale 1ns/1ps
`default_nettype none
module pmc_host_model (
    input  wire logic          clk_i,
    input  wire logic          ready_i,
    input  wire logic          rd_valid_i,
    input  wire logic [31:0]   rd_data_i,
    output pmc_pkg::pmc_req_t  req_o
);
    initial req_o = '0;

    // One request, driven off the falling edge and held until taken.
    // Storage commands are issued only where a test needs them
    task automatic access(input logic w, input logic [15:0] id, input logic [31:0] d,
                          output logic [31:0] q, output logic v);
        @(negedge clk_i);
        req_o = '{wr: w, rd: ~w, id: id, data: d};
        while (ready_i !== 1'b1) begin // Hold while the store is busy
            @(negedge clk_i);
        end
        @(posedge clk_i);
        @(negedge clk_i);
        q = rd_data_i;
        v = rd_valid_i;
        // Released lines show inverted values, not the last ones
        req_o = '{wr: 1'b0, rd: 1'b0, id: ~id, data: ~d};
    endtask
endmodule // pmc_host_model
`default_nettype wire

// >>> parameter_store_maintenance_cmds_bench.sv
// Testbench of the parameter store and maintenance command decode.
// Assumes pmc_top with a short store guard time and the host model.
`timescale 1ns/1ps
`default_nettype none
module parameter_store_maintenance_cmds_bench;
    logic                clk;
    logic                arst_n;
    logic                motion;
    logic                pfail;
    logic [5:0]          app_idx;
    logic                ready;
    logic                busy;
    logic [5:0]          echo;
    logic                rdv;
    logic [31:0]         rdd;
    logic [7:0]          alarm;
    logic [3:0]          sel;
    logic [31:0]         app;
    pmc_pkg::pmc_req_t   req;
    pmc_pkg::pmc_act_t   act;
    logic [31:0]         q;
    logic                v;
    logic [11:0]         act_last;
    int                  act_cnt;
    int                  n;
    int                  fails;
    int                  n_tests;
    logic [15:0]         ids [12] = '{16'h00C0, 16'h00C2, 16'h00C5, 16'h00CB, 16'h00CC,
        16'h00CD, 16'h00CE, 16'h00CF, 16'h00D1, 16'h00D2, 16'h00D3, 16'h00D4};

    // Short guard so the post-write window fits the run
    pmc_top #(.NV_GUARD_CYCLES(20)) i_dut (
        .core_clk_i(clk), .arst_n_i(arst_n), .req_i(req), .req_ready_o(ready),
        .rd_valid_o(rdv), .rd_data_o(rdd), .motion_busy_i(motion), .pwr_fail_i(pfail),
        .alarm_code_o(alarm), .almh_sel_o(sel), .act_o(act), .busy_o(busy),
        .app_idx_i_echo_o(echo), .app_idx_i(app_idx), .app_data_o(app));

    pmc_host_model i_host (.clk_i(clk), .ready_i(ready), .rd_valid_i(rdv),
        .rd_data_i(rdd), .req_o(req));

    // Clock at 10 MHz
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Counts action pulses, so a double or missing pulse shows up
    always @(negedge clk) begin
        if (act !== '0) begin
            act_cnt++;
            act_last = act;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] id, input logic [31:0] d);
        i_host.access(1'b1, id, d, q, v);
    endtask

    task automatic rd_chk(input logic [15:0] id, input logic [31:0] e);
        i_host.access(1'b0, id, 32'h0, q, v);
        chk({31'h0, v}, 32'h1);
        chk(q, e);
    endtask

    task automatic app_chk(input logic [5:0] i, input logic [31:0] e);
        @(negedge clk);
        app_idx = i;
        repeat (2) @(negedge clk);
        chk({26'h0, echo}, {26'h0, i});
        chk(app, e);
    endtask

    // Bounded wait for idle; n counts the busy cycles seen
    task automatic wait_idle();
        n = 0;
        while (ready !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
    endtask

    // Power cycle: reset low for k cycles, then the boot copy runs
    task automatic pcycle(input int k);
        @(negedge clk);
        arst_n = 1'b0;
        repeat (k) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        chk({31'h0, ready}, 32'h0);
        chk({31'h0, busy}, 32'h1);
        wait_idle();
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog, well beyond the thousand or so cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        complete_run();
    end

    // Test sequence
    initial begin
        fails = 0;
        n_tests = 0;
        act_cnt = 0;
        arst_n = 1'b0;
        motion = 1'b0;
        pfail = 1'b0;
        app_idx = 6'h00;
        pcycle(16);
        wr(16'h00CA, 32'h0);
        wr(16'h00C9, 32'h0);
        wait_idle();
        chk(n, 64);
        repeat (30) @(negedge clk);
        pcycle(4);
        $display("test baseline done");
        rd_chk(16'h00D5, 32'h0);
        wr(16'h00D5, 32'h5);
        rd_chk(16'h00D5, 32'h5);
        wr(16'h00D5, 32'hB);
        wr(16'h00D5, 32'h0);
        rd_chk(16'h00D5, 32'h5);
        wr(16'h00D5, 32'hA);
        chk({28'h0, sel}, 32'hA);
        $display("test selector done");
        wr(16'h0100, 32'hA1A1_0001);
        app_chk(6'h00, 32'hA1A1_0001);
        rd_chk(16'h0100, 32'hA1A1_0001);
        motion = 1'b1;
        wr(16'h0101, 32'hB1B1_0002);
        app_chk(6'h01, 32'h0);
        motion = 1'b0;
        app_chk(6'h01, 32'hB1B1_0002);
        wr(16'h0102, 32'hC1C1_0003);
        app_chk(6'h02, 32'h0);
        wr(16'h0103, 32'hD1D1_0004);
        wr(16'h00C6, 32'h0);
        app_chk(6'h02, 32'hC1C1_0003);
        app_chk(6'h03, 32'h0);
        $display("test classes done");
        wr(16'h013C, 32'hEE00_00EE);
        wr(16'h00C7, 32'h0);
        rd_chk(16'h013C, 32'hEE00_00EE);
        rd_chk(16'h0100, 32'h0);
        wr(16'h00CA, 32'h0);
        rd_chk(16'h013C, 32'h0);
        $display("test init done");
        wr(16'h0100, 32'h0000_0055);
        // Init above cleared the class D word, so write it again before storing
        wr(16'h0103, 32'hD1D1_0004);
        wr(16'h00C9, 32'h0);
        wr(16'h0100, 32'h0000_0066);
        rd_chk(16'h0100, 32'h0000_0066);
        wr(16'h00C8, 32'h0);
        rd_chk(16'h0100, 32'h0000_0055);
        wr(16'h0100, 32'h0000_0077);
        repeat (30) @(negedge clk);
        pcycle(4);
        rd_chk(16'h0100, 32'h0000_0055);
        app_chk(6'h03, 32'hD1D1_0004);
        app_chk(6'h00, 32'h0000_0055);
        $display("test store done");
        for (int k = 0; k < 12; k++) begin
            act_cnt = 0;
            wr(ids[k], 32'hFFFF_FFFF ^ k);
            repeat (3) @(negedge clk);
            chk(act_cnt, 1);
            chk({20'h0, act_last}, 32'h800 >> k);
        end
        $display("test actions done");
        wr(16'h00C9, 32'h0);
        // Power loss while the batch write itself runs
        pfail = 1'b1;
        @(negedge clk);
        pfail = 1'b0;
        chk({24'h0, alarm}, 32'h41);
        wait_idle();
        wr(16'h00C0, 32'h0);
        chk({24'h0, alarm}, 32'h0);
        // Power loss inside the guard time after the write
        pfail = 1'b1;
        @(negedge clk);
        pfail = 1'b0;
        chk({24'h0, alarm}, 32'h41);
        wr(16'h00C0, 32'h0);
        @(negedge clk);
        chk({24'h0, alarm}, 32'h0);
        repeat (30) @(negedge clk);
        pfail = 1'b1;
        @(negedge clk);
        pfail = 1'b0;
        chk({24'h0, alarm}, 32'h0);
        $display("test alarm done");
        complete_run();
    end
endmodule // parameter_store_maintenance_cmds_bench
`default_nettype wire
